// ===== verif/pad_config_decoder_sva.sv
`timescale 1ns/1ps
module pad_config_decoder_sva
   import pad_cfg_pkg::*;
(
   input logic        core_clk,        // Clock
   input logic        reset,           // Reset
   input logic        clk_en,          // Enable
   input logic        avs_read,        // Read
   input logic        avs_write,       // Write
   input logic        avs_waitrequest, // Stall
   input logic [15:0] mtx_out_en,      // Matrix enable
   input logic        i2c_scl_oe,      // Clock drive
   input logic        i2c_sda_in,      // Data input
   input logic [15:0] pad_oe,          // Pin enable
   input logic [1:0]  vin_virtual,     // Routed
   input logic [15:0] pp_en,           // Push-pull
   input logic [15:0] odn_en,          // NMOS drain
   input logic [15:0] odp_en,          // PMOS drain
   input logic [15:0] drv2x_en,        // 2x
   input logic [15:0] drv4x_en,        // 4x
   input logic [15:0] pull_up_en,      // Pull-up
   input logic [15:0] pull_dn_en       // Pull-down
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence rd_first; avs_read && avs_waitrequest; endsequence
   sequence rd_done; !avs_waitrequest; endsequence
   a_read_wait: assert property ($rose(avs_read) |-> rd_first ##1 rd_done) else $error("read stall wrong");
   a_write_nowait: assert property (avs_write && clk_en |-> !avs_waitrequest) else $error("write stalled");
   a_pad0_input: assert property (!pad_oe[0] && !pp_en[0] && !odn_en[0]) else $error("pad0 drives");
   a_pad0_pulldn: assert property (!pull_up_en[0]) else $error("pad0 pull-up");
   a_shared_pulldn: assert property (pull_up_en[7:6] == 2'h0) else $error("shared pull-up");
   a_pull_excl: assert property ((pull_up_en & pull_dn_en) == 16'h0) else $error("both pulls");
   a_shared_modes: assert property ((pp_en[7:6] | odp_en[7:6]) == 2'h0) else $error("shared mode");
   a_oe_gated: assert property ((pad_oe & OE_PADS & ~mtx_out_en) == 16'h0) else $error("oe ungated");
   a_drv_excl: assert property ((pp_en & (odn_en | odp_en)) == 16'h0) else $error("two drivers");
   a_x4_pad8: assert property (drv4x_en[8] |-> mtx_out_en[8] && odn_en[8] && !drv2x_en[8])
      else $error("pad8 4x");
   a_x4_pad9: assert property (drv4x_en[9] |-> odn_en[9] && !drv2x_en[9]) else $error("pad9 4x");
   a_scl_route: assert property (vin_virtual[0] |-> pad_oe[6] == (odn_en[6] && i2c_scl_oe)) else $error("scl route");
   a_sda_route: assert property (!vin_virtual[1] |-> i2c_sda_in) else $error("sda idle");
endmodule : pad_config_decoder_sva
bind pad_config_decoder pad_config_decoder_sva u_sva (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mtx_out_en(mtx_out_en),
   .i2c_scl_oe(i2c_scl_oe),
   .i2c_sda_in(i2c_sda_in), .pad_oe(pad_oe), .vin_virtual(vin_virtual), .pp_en(pp_en), .odn_en(odn_en),
   .odp_en(odp_en), .drv2x_en(drv2x_en), .drv4x_en(drv4x_en), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en));

// ===== verif/pad_config_decoder_tb.sv
`timescale 1ns/1ps
module pad_config_decoder_tb;
   import pad_cfg_pkg::*;
   typedef struct packed {logic [3:0] pad; logic [7:0] cfg; logic en; logic [11:0] ex; logic [11:0] mk;} row_t;
   localparam row_t ROWS [26] = '{
      '{4'h0,8'h05,1'b0,12'h401,12'hff3}, '{4'h0,8'h0b,1'b0,12'h201,12'hff3}, '{4'h0,8'h0c,1'b0,12'h000,12'hff0},
      '{4'h1,8'h0d,1'b0,12'h402,12'hff3}, '{4'h1,8'h2d,1'b1,12'h848,12'h878}, '{4'h3,8'h60,1'b1,12'h828,12'h878},
      '{4'h3,8'h40,1'b1,12'h820,12'h878}, '{4'h5,8'h18,1'b0,12'h080,12'hff0}, '{4'hd,8'h18,1'b0,12'h000,12'hff0},
      '{4'hf,8'h10,1'b0,12'h200,12'hff0}, '{4'h2,8'h00,1'b0,12'h100,12'hff0}, '{4'h2,8'h41,1'b0,12'h848,12'h878},
      '{4'h4,8'h50,1'b0,12'h820,12'h878}, '{4'hc,8'h60,1'b0,12'h010,12'h878}, '{4'h4,8'h30,1'b0,12'h080,12'hff0},
      '{4'h9,8'h70,1'b0,12'h8a0,12'hff0}, '{4'he,8'h30,1'b0,12'h000,12'hff0}, '{4'hc,8'h14,1'b0,12'h401,12'hff3},
      '{4'h6,8'h57,1'b0,12'h829,12'h87b}, '{4'h7,8'h42,1'b0,12'h000,12'h870}, '{4'h7,8'h1e,1'b0,12'h401,12'hff3},
      '{4'h8,8'hc0,1'b1,12'h824,12'h87c}, '{4'h8,8'he0,1'b1,12'h828,12'h87c}, '{4'h8,8'hc0,1'b0,12'h000,12'h874},
      '{4'h9,8'hd0,1'b0,12'h824,12'h87c}, '{4'h9,8'hc0,1'b0,12'h840,12'h87c}};
   logic        core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, clk_en = 1'b1;
   logic        i2c_scl_oe = 1'b0, i2c_sda_oe = 1'b0, i2c_scl_in, i2c_sda_in, avs_waitrequest;
   logic [5:0]  avs_address = 6'h00;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, pull_val, d;
   logic [15:0] mtx_out_data = 16'h0, mtx_out_en = 16'h0, ext_level = 16'h0, pad_in, pad_out, pad_oe, mtx_in;
   logic [15:0] smt_en, lv_en, wosmt_en, aio_en, pp_en, odn_en, odp_en, drv2x_en, drv4x_en, pull_up_en, pull_dn_en;
   logic [1:0]  vin_virtual;
   int          error_cnt = 0, samples_checked = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   pad_ext_model ext (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));
   pad_config_decoder dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .mtx_out_data(mtx_out_data),
      .mtx_out_en(mtx_out_en), .i2c_scl_oe(i2c_scl_oe), .i2c_sda_oe(i2c_sda_oe), .pad_out(pad_out), .pad_oe(pad_oe),
      .mtx_in(mtx_in), .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in), .vin_virtual(vin_virtual), .smt_en(smt_en),
      .lv_en(lv_en), .wosmt_en(wosmt_en), .aio_en(aio_en), .pp_en(pp_en), .odn_en(odn_en), .odp_en(odp_en),
      .drv2x_en(drv2x_en), .drv4x_en(drv4x_en), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
      .pull_val(pull_val));
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request held until the rising edge that sees the stall low; data taken there
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rv);
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= !w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, 4'h1, x);
   endtask : wr
   function automatic logic [11:0] obs(input int p);
      obs = {pad_oe[p], smt_en[p], lv_en[p], wosmt_en[p], aio_en[p], pp_en[p], odn_en[p], odp_en[p],
             drv2x_en[p], drv4x_en[p], pull_up_en[p], pull_dn_en[p]};
   endfunction : obs
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      for (int p = 0; p < 16; p++) begin
         bus(1'b0, p[5:0], 32'h0, 4'h0, d);
         chk("cfg_reset", {24'h0, CFG_RESET}, d);
      end
      chk("pull_reset", 32'h0, pull_val);
      chk("oe_reset", 32'h0, {16'h0, pad_oe | pp_en | odn_en | odp_en});
      bus(1'b1, 6'h08, 32'hffff_ffff, 4'hf, d);
      bus(1'b0, 6'h08, 32'h0, 4'h0, d);
      chk("cfg_width", 32'h0000_00ff, d);
      bus(1'b1, 6'h08, 32'h0, 4'he, d);
      bus(1'b0, 6'h08, 32'h0, 4'h0, d);
      chk("cfg_byteen", 32'h0000_00ff, d);
      bus(1'b1, 6'h20, 32'h55, 4'hf, d);
      bus(1'b0, 6'h20, 32'h0, 4'h0, d);
      chk("unmapped", UNMAPPED_RD, d);
      foreach (ROWS[i]) begin
         wr({2'h0, ROWS[i].pad}, {24'h0, ROWS[i].cfg});
         mtx_out_en <= {15'h0, ROWS[i].en} << ROWS[i].pad;
         @(negedge core_clk);
         chk("pad_decode", {20'h0, ROWS[i].ex}, {20'h0, obs(ROWS[i].pad) & ROWS[i].mk});
      end
      for (int v = 0; v < 4; v++) begin
         wr(6'h00, {30'h0, v[1:0]});
         wr(6'h0b, {29'h0, v[1:0], 1'b0});
         @(negedge core_clk);
         chk("pull_val", {28'h0, v[1:0], v[1:0]}, {28'h0, pull_val[23:22], pull_val[1:0]});
      end
      wr(6'h01, 32'h0);
      wr(6'h0d, 32'h18);
      wr(6'h02, 32'h40);
      mtx_out_en <= 16'h0002; mtx_out_data <= 16'h0006; ext_level <= 16'h2000;
      repeat (6) @(negedge core_clk);
      chk("pad_drive", 32'h3, {30'h0, pad_out[2:1] & pad_oe[2:1]});
      chk("mtx_in_drv", 32'h1, {31'h0, mtx_in[1]});
      chk("mtx_in_rsv", 32'h0, {31'h0, mtx_in[13]});
      bus(1'b0, PAD_IN_ADDR, 32'h0, 4'h0, d);
      chk("pin_levels", 32'h0000_2006, d);
      bus(1'b0, PAD_STAT_ADDR, 32'h0, 4'h0, d);
      chk("pad_status", 32'h0246_0006, d);
      mtx_out_en <= 16'h0;
      repeat (6) @(negedge core_clk);
      chk("mtx_in_rel", 32'h0, {31'h0, mtx_in[1]});
      @(posedge core_clk);
      i2c_scl_oe <= 1'b1; i2c_sda_oe <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(6'h06 + k[5:0], 32'h50);
         @(negedge core_clk);
         chk("route_on", 32'h3, {30'h0, vin_virtual[k], pad_oe[6 + k]});
         wr(6'h06 + k[5:0], 32'h52);
         @(negedge core_clk);
         chk("route_off", 32'h1, {30'h0, vin_virtual[k], (k == 0) ? i2c_scl_in : i2c_sda_in});
      end
      @(posedge core_clk);
      clk_en <= 1'b0;
      ext_level <= 16'hffff;
      repeat (6) @(negedge core_clk);
      chk("in_frozen", 32'h0, {31'h0, mtx_in[15]});
      @(posedge core_clk);
      clk_en <= 1'b1;
      repeat (6) @(negedge core_clk);
      chk("in_thawed", 32'h1, {31'h0, mtx_in[15]});
      @(posedge core_clk);
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      bus(1'b0, 6'h08, 32'h0, 4'h0, d);
      chk("cfg_rereset", {24'h0, CFG_RESET}, d);
      chk("oe_rereset", 32'h0, {16'h0, pad_oe});
      report_and_stop();
   end
endmodule : pad_config_decoder_tb

// ===== verif/pad_ext_model.sv
`timescale 1ns/1ps
module pad_ext_model (
   input  logic [15:0] pad_out,   // Driven value
   input  logic [15:0] pad_oe,    // Drive enable
   input  logic [15:0] ext_level, // Level when released
   output logic [15:0] pad_in     // Pin level
);
   // Released pins take the external level, never the last driven one
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pad_ext_model

// ===== verilog/pad_cfg_pkg.sv
package pad_cfg_pkg;
   // ---------------------------------------------------------------
   // Register map (word index; byte address = index * 4)
   // ---------------------------------------------------------------
   localparam int         NUM_PADS      = 16;
   localparam logic [5:0] PAD_CFG_BASE  = 6'h00;
   localparam logic [5:0] PAD_STAT_ADDR = 6'h10;
   localparam logic [5:0] PAD_IN_ADDR   = 6'h11;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Field positions within each config word
   // ---------------------------------------------------------------
   // Pad 0: [1:0] value, [3:2] mode
   localparam int P0_VAL_LSB   = 0;
   localparam int P0_MODE_LSB  = 2;
   // Output-enable pads: [0] dir, [2:1] value, [4:3] in mode, [6:5] out mode, [7] 4x
   localparam int OE_DIR_BIT   = 0;
   localparam int OE_VAL_LSB   = 1;
   localparam int OE_IN_LSB    = 3;
   localparam int OE_OUT_LSB   = 5;
   localparam int X4_BIT       = 7;
   // Three-bit pads: [0] strength, [1] dir, [3:2] value, [6:4] mode, [7] 4x (pad 9)
   localparam int T3_STR_BIT   = 0;
   localparam int T3_DIR_BIT   = 1;
   localparam int T3_VAL_LSB   = 2;
   localparam int T3_MODE_LSB  = 4;
   // Shared pads 6/7: [0] strength, [1] select, [3:2] value, [6:4] mode
   localparam int SH_SEL_BIT   = 1;
   // ---------------------------------------------------------------
   // Pad groups as bit masks over pad index
   // ---------------------------------------------------------------
   localparam logic [15:0] OE_PADS     = 16'had2a; // 1,3,5,8,10,11,13,15
   localparam logic [15:0] OE_ANALOG   = 16'h8d20; // 5,8,10,11,15
   localparam logic [15:0] T3_PADS     = 16'h5214; // 2,4,9,12,14
   localparam logic [15:0] T3_ANALOG   = 16'h1210; // 4,9,12
   localparam logic [15:0] SH_PADS     = 16'h00c0; // 6,7
   localparam logic [15:0] X4_PADS     = 16'h0300; // 8,9
   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] RES_FLOAT = 2'h0;
   localparam logic [1:0] IN_PLAIN  = 2'h0;
   localparam logic [1:0] IN_SMT    = 2'h1;
   localparam logic [1:0] IN_LV     = 2'h2;
   localparam logic [1:0] IN_ANA    = 2'h3;
   localparam logic [1:0] OUT_PP1   = 2'h0;
   localparam logic [1:0] OUT_PP2   = 2'h1;
   localparam logic [1:0] OUT_OD1   = 2'h2;
   localparam logic [1:0] OUT_OD2   = 2'h3;
   localparam logic [2:0] M3_PLAIN  = 3'h0;
   localparam logic [2:0] M3_SMT    = 3'h1;
   localparam logic [2:0] M3_LV     = 3'h2;
   localparam logic [2:0] M3_ANA    = 3'h3;
   localparam logic [2:0] M3_PP     = 3'h4;
   localparam logic [2:0] M3_ODN    = 3'h5;
   localparam logic [2:0] M3_ODP    = 3'h6;
   localparam logic [2:0] M3_ANA_OD = 3'h7;

   typedef enum {DRV_OFF, DRV_PP, DRV_ODN, DRV_ODP} drv_kind_t;
endpackage : pad_cfg_pkg

// ===== verilog/pad_config_decoder.sv
// Operation
// - Resistor value code: float, 10k, 100k, 1M
// - Pad 0 pull-down only, two-bit value
// - Pad 0 input only, code 3 reserved
// - Direction bit: 0 pull-down, 1 pull-up
// - OE pads: input field or output field
// - OE output field: PP/OD at 1x/2x
// - OE input field; code 3 analog or reserved
// - Codes 4,5,6: push-pull, NMOS OD, PMOS OD
// - Codes 3,7 analog on 4,9,12 only
// - Strength bit: 0 is 1x, 1 is 2x
// - Pad 6 select 0 routes serial clock
// - Pad 7 select 0 routes serial data
// - Pads 6,7 allow inputs and NMOS OD
// - Pads 6,7 pull-down only, two-bit value
// - Pad 8 4x only with OE, OD1x
// - Pad 9 4x only with NMOS OD
// - OE pads take data, OE from matrix
// - Three-bit pads derive OE from mode
`timescale 1ns/1ps
module pad_config_decoder
   import pad_cfg_pkg::*;
(
   input  wire logic        core_clk,          // System clock
   input  wire logic        reset,             // Synchronous reset, active high
   input  wire logic        clk_en,            // Freezes all state when low
   input  wire logic [5:0]  avs_address,       // Word address
   input  wire logic        avs_read,          // Read request
   input  wire logic        avs_write,         // Write request
   input  wire logic [31:0] avs_writedata,     // Write data
   input  wire logic [3:0]  avs_byteenable,    // Byte enables
   output logic      [31:0] avs_readdata,      // Read data
   output logic             avs_waitrequest,   // Stall
   input  wire logic [15:0] pad_in,            // Pin level per pad
   input  wire logic [15:0] mtx_out_data,      // Matrix output data
   input  wire logic [15:0] mtx_out_en,        // Matrix output enable
   input  wire logic        i2c_scl_oe,        // Serial clock low drive
   input  wire logic        i2c_sda_oe,        // Serial data low drive
   output logic      [15:0] pad_out,           // Pin output value
   output logic      [15:0] pad_oe,            // Pin output enable
   output logic      [15:0] mtx_in,            // Digital in to matrix
   output logic             i2c_scl_in,        // Serial clock input
   output logic             i2c_sda_in,        // Serial data input
   output logic      [1:0]  vin_virtual,       // Virtual inputs 0,1 select
   output logic      [15:0] smt_en,            // Schmitt input enable
   output logic      [15:0] lv_en,             // Low-voltage input enable
   output logic      [15:0] wosmt_en,          // Plain input enable
   output logic      [15:0] aio_en,            // Analog path enable
   output logic      [15:0] pp_en,             // Push-pull driver enable
   output logic      [15:0] odn_en,            // NMOS open-drain enable
   output logic      [15:0] odp_en,            // PMOS open-drain enable
   output logic      [15:0] drv2x_en,          // 2x strength
   output logic      [15:0] drv4x_en,          // 4x drive
   output logic      [15:0] pull_up_en,        // Pull-up direction
   output logic      [15:0] pull_dn_en,        // Pull-down direction
   output logic      [31:0] pull_val           // Two-bit value per pad
);

   // ---------------------------------------------------------------
   // Config storage
   // ---------------------------------------------------------------
   logic [7:0]  cfg_r [NUM_PADS];
   logic [15:0] sync1_r, sync2_r, sync3_r, in_r;
   logic        rd_pend_r;

   function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      merge_byte = be[0] ? wd[7:0] : old;
   endfunction : merge_byte

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_PADS; i++) begin
            cfg_r[i] <= CFG_RESET;
         end
      end else if (clk_en && avs_write && avs_address < 6'(NUM_PADS)) begin
         cfg_r[avs_address[3:0]] <= merge_byte(cfg_r[avs_address[3:0]], avs_writedata, avs_byteenable);
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchroniser, change accepted when stages 2 and 3 agree
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1_r <= 16'h0000;
         sync2_r <= 16'h0000;
         sync3_r <= 16'h0000;
         in_r    <= 16'h0000;
      end else if (clk_en) begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         for (int i = 0; i < NUM_PADS; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               in_r[i] <= sync3_r[i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus slave: writes in one cycle, reads answer one cycle later
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_pend_r    <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (clk_en) begin
         rd_pend_r <= avs_read && !rd_pend_r;
         if (avs_read && !rd_pend_r) begin
            if (avs_address < 6'(NUM_PADS)) begin
               avs_readdata <= {24'h000000, cfg_r[avs_address[3:0]]};
            end else if (avs_address == PAD_STAT_ADDR) begin
               avs_readdata <= {pad_oe, mtx_in};
            end else if (avs_address == PAD_IN_ADDR) begin
               avs_readdata <= {16'h0000, in_r};
            end else begin
               avs_readdata <= UNMAPPED_RD;
            end
         end
      end
   end

   // Stall every request while frozen, so no write is dropped unseen
   assign avs_waitrequest = (avs_read && !rd_pend_r) || (!clk_en && (avs_read || avs_write));

   // ---------------------------------------------------------------
   // Per-pad decode
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] c;
      logic [1:0] val;
      logic [1:0] im;
      logic [2:0] m3;
      logic       oe;
      logic       rsvd;
      logic       sh_ena;
      drv_kind_t  kind;
      c           = 8'h00;
      val         = 2'h0;
      im          = 2'h0;
      m3          = 3'h0;
      oe          = 1'b0;
      rsvd        = 1'b0;
      sh_ena      = 1'b0;
      kind        = DRV_OFF;
      pad_out     = 16'h0000;
      pad_oe      = 16'h0000;
      mtx_in      = 16'h0000;
      smt_en      = 16'h0000;
      lv_en       = 16'h0000;
      wosmt_en    = 16'h0000;
      aio_en      = 16'h0000;
      pp_en       = 16'h0000;
      odn_en      = 16'h0000;
      odp_en      = 16'h0000;
      drv2x_en    = 16'h0000;
      drv4x_en    = 16'h0000;
      pull_up_en  = 16'h0000;
      pull_dn_en  = 16'h0000;
      pull_val    = 32'h0;
      i2c_scl_in  = 1'b1;
      i2c_sda_in  = 1'b1;
      vin_virtual = 2'h0;
      for (int p = 0; p < NUM_PADS; p++) begin
         c = cfg_r[p];
         kind = DRV_OFF;
         rsvd = 1'b0;
         oe = 1'b0;
         im = IN_PLAIN;
         m3 = M3_PLAIN;
         if (p == 0) begin
            val = c[P0_VAL_LSB +: 2];
            pull_dn_en[p] = (val != RES_FLOAT);
            im = c[P0_MODE_LSB +: 2];
            rsvd = (im == IN_ANA);
         end else if (OE_PADS[p]) begin
            val = c[OE_VAL_LSB +: 2];
            pull_up_en[p] = (val != RES_FLOAT) && c[OE_DIR_BIT];
            pull_dn_en[p] = (val != RES_FLOAT) && !c[OE_DIR_BIT];
            oe = mtx_out_en[p];
            if (oe) begin
               case (c[OE_OUT_LSB +: 2])
                  OUT_PP1: kind = DRV_PP;
                  OUT_PP2: begin
                     kind        = DRV_PP;
                     drv2x_en[p] = 1'b1;
                  end
                  OUT_OD1: kind = DRV_ODN;
                  OUT_OD2: begin
                     kind        = DRV_ODN;
                     drv2x_en[p] = 1'b1;
                  end
                  default: kind = DRV_OFF;
               endcase
               drv4x_en[p] = X4_PADS[p] && c[X4_BIT] && (c[OE_OUT_LSB +: 2] == OUT_OD1);
            end else begin
               im = c[OE_IN_LSB +: 2];
               if (im == IN_ANA) begin
                  rsvd = !OE_ANALOG[p];
                  aio_en[p] = OE_ANALOG[p];
               end
            end
         end else if (SH_PADS[p]) begin
            val = c[T3_VAL_LSB +: 2];
            pull_dn_en[p] = (val != RES_FLOAT);
            m3 = c[T3_MODE_LSB +: 3];
            drv2x_en[p] = c[T3_STR_BIT];
            sh_ena = !c[SH_SEL_BIT];
            vin_virtual[p[0]] = sh_ena;
            case (m3)
               M3_PLAIN, M3_SMT, M3_LV: im = m3[1:0];
               M3_ODN: kind = DRV_ODN;
               default: rsvd = 1'b1;
            endcase
         end else begin
            val = c[T3_VAL_LSB +: 2];
            pull_up_en[p] = (val != RES_FLOAT) && c[T3_DIR_BIT];
            pull_dn_en[p] = (val != RES_FLOAT) && !c[T3_DIR_BIT];
            drv2x_en[p] = c[T3_STR_BIT];
            m3 = c[T3_MODE_LSB +: 3];
            case (m3)
               M3_PLAIN, M3_SMT, M3_LV: im = m3[1:0];
               M3_PP:  kind = DRV_PP;
               M3_ODN: kind = DRV_ODN;
               M3_ODP: kind = DRV_ODP;
               M3_ANA: begin
                  rsvd = !T3_ANALOG[p];
                  aio_en[p] = T3_ANALOG[p];
               end
               M3_ANA_OD: begin
                  rsvd = !T3_ANALOG[p];
                  aio_en[p] = T3_ANALOG[p];
                  kind = T3_ANALOG[p] ? DRV_ODN : DRV_OFF;
               end
               default: rsvd = 1'b1;
            endcase
            drv4x_en[p] = X4_PADS[p] && c[X4_BIT] && (m3 == M3_ODN);
         end
         pull_val[2*p +: 2] = val;
         if (rsvd) begin
            kind = DRV_OFF;
            drv2x_en[p] = 1'b0;
         end else if (aio_en[p] && kind == DRV_OFF) begin
            // Analog only: digital input disabled
         end else if (kind == DRV_OFF || p == 0) begin
            wosmt_en[p] = (im == IN_PLAIN);
            smt_en[p]   = (im == IN_SMT);
            lv_en[p]    = (im == IN_LV);
         end
         case (kind)
            DRV_PP: begin
               pp_en[p]   = 1'b1;
               pad_oe[p]  = 1'b1;
               pad_out[p] = mtx_out_data[p];
            end
            DRV_ODN: begin
               odn_en[p]  = 1'b1;
               pad_oe[p]  = (p == 6 && sh_ena) ? i2c_scl_oe :
                            (p == 7 && sh_ena) ? i2c_sda_oe : !mtx_out_data[p];
               pad_out[p] = 1'b0;
            end
            DRV_ODP: begin
               odp_en[p]  = 1'b1;
               pad_oe[p]  = mtx_out_data[p];
               pad_out[p] = 1'b1;
            end
            default: begin
               pad_oe[p]  = 1'b0;
               pad_out[p] = 1'b0;
            end
         endcase
         mtx_in[p] = rsvd ? 1'b0 : in_r[p];
         if (p == 6) begin
            i2c_scl_in = sh_ena ? in_r[p] : 1'b1;
         end
         if (p == 7) begin
            i2c_sda_in = sh_ena ? in_r[p] : 1'b1;
         end
      end
      drv2x_en = drv2x_en & (pp_en | odn_en | odp_en);
   end

endmodule : pad_config_decoder
